// File: rtl/gpio_ports.sv
// Multi-port GPIO with alternate function select, Avalon-MM register slave.
// Assumes pads outside resolve out/oe/pullup, and an LCD, PWM and
// interrupt controller that sit beside it on clk_sys.
//
// Operation
// - Port 1 eight-bit data register, resets zero
// - Port 1 direction bits: 0 input, 1 output
// - Port 1 pull-up per pin when bit set
// - Port 1 open drain per pin when set
// - Alternate select resets zero; 1 selects alternate
// - Interrupt 3 select routes port 4 pin 1
// - PWM select puts PWM/timer on port 1 pin 0
// - Port 1 control registers write-only, byte writes
// - Port 2 data, direction, pull-up registers
// - Small package drops port 2 pins 5, 7
// - Port 2 control registers write-only, byte writes
// - Port 4 data, direction and pull-ups
// - Port 4 pins shared with osc, reset, interrupt
// - Flash option frees main osc and reset pins; the reset pin stays input-only here either way
// - Sub clock disable frees sub-oscillator pins
// - Port 4 control registers write-only, byte writes
// - Port 5 selectable to segments 0 to 7
// - Port 6 selectable to segments 8 to 15
// - Port 7 selectable to segments 16 to 23
// - Port 5-7 direction registers write-only, unreadable
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gpio_cfg.svh"
module gpio_ports
	import gpio_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [7:0] port1_pin_in,
	output logic [7:0] port1_pin_out,
	output logic [7:0] port1_pin_oe,
	output logic [7:0] port1_pin_pullup,
	input wire logic [7:0] port2_pin_in,
	output logic [7:0] port2_pin_out,
	output logic [7:0] port2_pin_oe,
	output logic [7:0] port2_pin_pullup,
	input wire logic [7:0] port4_pin_in,
	output logic [7:0] port4_pin_out,
	output logic [7:0] port4_pin_oe,
	output logic [7:0] port4_pin_pullup,
	input wire logic [7:0] port5_pin_in,
	output logic [7:0] port5_pin_out,
	output logic [7:0] port5_pin_oe,
	input wire logic [7:0] port6_pin_in,
	output logic [7:0] port6_pin_out,
	output logic [7:0] port6_pin_oe,
	input wire logic [7:0] port7_pin_in,
	output logic [7:0] port7_pin_out,
	output logic [7:0] port7_pin_oe,
	input wire logic pwm_one_output,
	input wire logic [23:0] lcd_segment,
	input wire logic option_main_osc_as_io,
	input wire logic option_reset_as_io,
	output logic external_interrupt_three,
	output logic external_interrupt_two_select,
	output logic sub_clock_disable,
	output logic main_osc_pins_dedicated,
	output logic reset_pin_n
);
	// --------
	// Bus handshake: one wait state per access
	// --------
	logic ack_reg;
	logic [31:0] readdata_reg;
	wire req = read | write;
	wire [7:0] idx = address[9:2];
	wire aligned = (address[1:0] == 2'b00);
	wire wr_go = write & ack_reg & aligned & byteenable[0];
	wire rd_start = read & ~ack_reg;

	assign waitrequest = req & ~ack_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// --------
	// Address decode
	// --------
	wire hit_p1_data = (idx == `IDX_PORT1_DATA);
	wire hit_p1_dir = (idx == `IDX_PORT1_DIRECTION);
	wire hit_p1_pu = (idx == `IDX_PORT1_PULLUP_SELECT);
	wire hit_p1_od = (idx == `IDX_PORT1_OPEN_DRAIN_SELECT);
	wire hit_alt = (idx == `IDX_ALT_FUNCTION_SELECT_B);
	wire hit_p2_data = (idx == `IDX_PORT2_DATA);
	wire hit_p2_dir = (idx == `IDX_PORT2_DIRECTION);
	wire hit_p2_pu = (idx == `IDX_PORT2_PULLUP_SELECT);
	wire hit_p2_od = (idx == `IDX_PORT2_OPEN_DRAIN_SELECT);
	wire hit_p4_data = (idx == `IDX_PORT4_DATA);
	wire hit_p4_dir = (idx == `IDX_PORT4_DIRECTION);
	wire hit_p4_pu = (idx == `IDX_PORT4_PULLUP_SELECT);
	wire hit_p4_od = (idx == `IDX_PORT4_OPEN_DRAIN_SELECT);
	wire hit_p5_data = (idx == `IDX_PORT5_DATA);
	wire hit_p5_dir = (idx == `IDX_PORT5_DIRECTION);
	wire hit_p5_seg = (idx == `IDX_PORT5_SEGMENT_SELECT);
	wire hit_p6_data = (idx == `IDX_PORT6_DATA);
	wire hit_p6_dir = (idx == `IDX_PORT6_DIRECTION);
	wire hit_p6_seg = (idx == `IDX_PORT6_SEGMENT_SELECT);
	wire hit_p7_data = (idx == `IDX_PORT7_DATA);
	wire hit_p7_dir = (idx == `IDX_PORT7_DIRECTION);
	wire hit_p7_seg = (idx == `IDX_PORT7_SEGMENT_SELECT);
	wire hit_lcd = (idx == `IDX_LCD_CONTROL_REGISTER);
	wire [7:0] wbyte = writedata[7:0];

	// --------
	// Port registers
	// --------
	byte_t port1_data_reg;
	byte_t port1_direction_reg;
	byte_t port1_pullup_select_reg;
	byte_t port1_open_drain_select_reg;
	byte_t alt_function_select_b_reg;
	byte_t port2_data_reg;
	byte_t port2_direction_reg;
	byte_t port2_pullup_select_reg;
	byte_t port2_open_drain_select_reg;
	byte_t port4_data_reg;
	byte_t port4_direction_reg;
	byte_t port4_pullup_select_reg;
	byte_t port4_open_drain_select_reg;
	byte_t port5_data_reg;
	byte_t port5_direction_reg;
	byte_t port5_segment_select_reg;
	byte_t port6_data_reg;
	byte_t port6_direction_reg;
	byte_t port6_segment_select_reg;
	byte_t port7_data_reg;
	byte_t port7_direction_reg;
	byte_t port7_segment_select_reg;
	byte_t lcd_control_register_reg;

	// Port 1 and the shared alternate select
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			port1_data_reg <= `GPIO_RESET_BYTE;
			port1_direction_reg <= `GPIO_RESET_BYTE;
			port1_pullup_select_reg <= `GPIO_RESET_BYTE;
			port1_open_drain_select_reg <= `GPIO_RESET_BYTE;
			alt_function_select_b_reg <= `GPIO_RESET_BYTE;
		end else if (wr_go) begin
			if (hit_p1_data) port1_data_reg <= wbyte;
			if (hit_p1_dir) port1_direction_reg <= wbyte;
			if (hit_p1_pu) port1_pullup_select_reg <= wbyte;
			if (hit_p1_od) port1_open_drain_select_reg <= wbyte;
			if (hit_alt) alt_function_select_b_reg <= wbyte;
		end
	end

	// Port 2 and port 4
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			port2_data_reg <= `GPIO_RESET_BYTE;
			port2_direction_reg <= `GPIO_RESET_BYTE;
			port2_pullup_select_reg <= `GPIO_RESET_BYTE;
			port2_open_drain_select_reg <= `GPIO_RESET_BYTE;
			port4_data_reg <= `GPIO_RESET_BYTE;
			port4_direction_reg <= `GPIO_RESET_BYTE;
			port4_pullup_select_reg <= `GPIO_RESET_BYTE;
			port4_open_drain_select_reg <= `GPIO_RESET_BYTE;
		end else if (wr_go) begin
			if (hit_p2_data) port2_data_reg <= wbyte;
			if (hit_p2_dir) port2_direction_reg <= wbyte;
			if (hit_p2_pu) port2_pullup_select_reg <= wbyte;
			if (hit_p2_od) port2_open_drain_select_reg <= wbyte;
			if (hit_p4_data) port4_data_reg <= wbyte;
			if (hit_p4_dir) port4_direction_reg <= wbyte;
			if (hit_p4_pu) port4_pullup_select_reg <= wbyte;
			if (hit_p4_od) port4_open_drain_select_reg <= wbyte;
		end
	end

	// Segment-capable ports and the LCD control byte
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			port5_data_reg <= `GPIO_RESET_BYTE;
			port5_direction_reg <= `GPIO_RESET_BYTE;
			port5_segment_select_reg <= `GPIO_RESET_BYTE;
			port6_data_reg <= `GPIO_RESET_BYTE;
			port6_direction_reg <= `GPIO_RESET_BYTE;
			port6_segment_select_reg <= `GPIO_RESET_BYTE;
			port7_data_reg <= `GPIO_RESET_BYTE;
			port7_direction_reg <= `GPIO_RESET_BYTE;
			port7_segment_select_reg <= `GPIO_RESET_BYTE;
			lcd_control_register_reg <= `GPIO_RESET_BYTE;
		end else if (wr_go) begin
			if (hit_p5_data) port5_data_reg <= wbyte;
			if (hit_p5_dir) port5_direction_reg <= wbyte;
			if (hit_p5_seg) port5_segment_select_reg <= wbyte;
			if (hit_p6_data) port6_data_reg <= wbyte;
			if (hit_p6_dir) port6_direction_reg <= wbyte;
			if (hit_p6_seg) port6_segment_select_reg <= wbyte;
			if (hit_p7_data) port7_data_reg <= wbyte;
			if (hit_p7_dir) port7_direction_reg <= wbyte;
			if (hit_p7_seg) port7_segment_select_reg <= wbyte;
			if (hit_lcd) lcd_control_register_reg <= wbyte;
		end
	end

	// --------
	// Configuration option straps
	// --------
	// Options come from flash outside this clock; two stages before use
	logic opt_osc_a_reg;
	logic opt_osc_reg;
	logic opt_rst_a_reg;
	logic opt_rst_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			opt_osc_a_reg <= 1'b0;
			opt_osc_reg <= 1'b0;
			opt_rst_a_reg <= 1'b0;
			opt_rst_reg <= 1'b0;
		end else begin
			opt_osc_a_reg <= option_main_osc_as_io;
			opt_osc_reg <= opt_osc_a_reg;
			opt_rst_a_reg <= option_reset_as_io;
			opt_rst_reg <= opt_rst_a_reg;
		end
	end

	// --------
	// Pin sharing
	// --------
	wire sel_pwm = alt_function_select_b_reg[`ALT_PWM_ONE_BIT];
	wire sel_external_interrupt_three = alt_function_select_b_reg[`ALT_INT_THREE_BIT];
	wire sub_off = lcd_control_register_reg[`LCD_SUB_CLOCK_DISABLE_BIT];
	wire [7:0] p1_alt_sel = {7'b000_0000, sel_pwm};
	wire [7:0] p1_alt_out = {7'b000_0000, pwm_one_output};
	wire [7:0] p2_absent = SMALL_PACKAGE ? `PORT2_SMALL_PACKAGE_MASK : 8'h00;
	wire [7:0] p4_alt_sel = {6'b00_0000, sel_external_interrupt_three, 1'b0};
	// Reset pin is input-only either way; osc pins held unless released
	wire [7:0] p4_in_only = {1'b1, ~opt_osc_reg, ~opt_osc_reg, ~sub_off, ~sub_off, 3'b000};
	wire [7:0] p2_level;
	wire [7:0] p1_level;
	wire [7:0] p4_level;
	wire [7:0] p5_level;
	wire [7:0] p6_level;
	wire [7:0] p7_level;

	gpio_pin_cell #(.WIDTH(8)) u_port1 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port1_data_reg),
		.dir(port1_direction_reg), .open_drain(port1_open_drain_select_reg),
		.pull_sel(port1_pullup_select_reg), .alt_sel(p1_alt_sel), .alt_out(p1_alt_out),
		.alt_drive(8'h01), .in_only(8'h00), .pin_in(port1_pin_in),
		.pin_out(port1_pin_out), .pin_oe(port1_pin_oe), .pin_pullup(port1_pin_pullup), .level(p1_level)
	);

	gpio_pin_cell #(.WIDTH(8)) u_port2 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port2_data_reg),
		.dir(port2_direction_reg), .open_drain(port2_open_drain_select_reg),
		.pull_sel(port2_pullup_select_reg), .alt_sel(8'h00), .alt_out(8'h00),
		.alt_drive(8'h00), .in_only(p2_absent), .pin_in(port2_pin_in),
		.pin_out(port2_pin_out), .pin_oe(port2_pin_oe), .pin_pullup(port2_pin_pullup), .level(p2_level)
	);

	// Interrupt pin is an input while routed, hence no alternate drive
	gpio_pin_cell #(.WIDTH(8)) u_port4 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port4_data_reg),
		.dir(port4_direction_reg), .open_drain(port4_open_drain_select_reg),
		.pull_sel(port4_pullup_select_reg), .alt_sel(p4_alt_sel), .alt_out(8'h00),
		.alt_drive(8'h00), .in_only(p4_in_only), .pin_in(port4_pin_in),
		.pin_out(port4_pin_out), .pin_oe(port4_pin_oe), .pin_pullup(port4_pin_pullup), .level(p4_level)
	);

	gpio_pin_cell #(.WIDTH(8)) u_port5 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port5_data_reg),
		.dir(port5_direction_reg), .open_drain(8'h00),
		.pull_sel(8'h00), .alt_sel(port5_segment_select_reg), .alt_out(lcd_segment[7:0]),
		.alt_drive(8'hFF), .in_only(8'h00), .pin_in(port5_pin_in),
		.pin_out(port5_pin_out), .pin_oe(port5_pin_oe), .pin_pullup(), .level(p5_level)
	);

	gpio_pin_cell #(.WIDTH(8)) u_port6 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port6_data_reg),
		.dir(port6_direction_reg), .open_drain(8'h00),
		.pull_sel(8'h00), .alt_sel(port6_segment_select_reg), .alt_out(lcd_segment[15:8]),
		.alt_drive(8'hFF), .in_only(8'h00), .pin_in(port6_pin_in),
		.pin_out(port6_pin_out), .pin_oe(port6_pin_oe), .pin_pullup(), .level(p6_level)
	);

	gpio_pin_cell #(.WIDTH(8)) u_port7 (
		.clk_sys(clk_sys), .rst_n(rst_n), .latch(port7_data_reg),
		.dir(port7_direction_reg), .open_drain(8'h00),
		.pull_sel(8'h00), .alt_sel(port7_segment_select_reg), .alt_out(lcd_segment[23:16]),
		.alt_drive(8'hFF), .in_only(8'h00), .pin_in(port7_pin_in),
		.pin_out(port7_pin_out), .pin_oe(port7_pin_oe), .pin_pullup(), .level(p7_level)
	);

	// --------
	// Side-band outputs
	// --------
	assign external_interrupt_three = sel_external_interrupt_three & p4_level[`PORT4_INT_THREE_PIN];
	assign external_interrupt_two_select = alt_function_select_b_reg[`ALT_INT_TWO_BIT];
	assign sub_clock_disable = sub_off;
	assign main_osc_pins_dedicated = ~opt_osc_reg;
	assign reset_pin_n = opt_rst_reg | p4_level[`PORT4_RESET_PIN];

	// --------
	// Read path
	// --------
	// Outputs read back their latch, inputs the synchronised pin
	wire [7:0] p1_rd = (port1_data_reg & port1_direction_reg) | (p1_level & ~port1_direction_reg);
	wire [7:0] p2_rd = ((port2_data_reg & port2_direction_reg) | (p2_level & ~port2_direction_reg)) & ~p2_absent;
	wire [7:0] p4_rd = (port4_data_reg & port4_direction_reg) | (p4_level & ~port4_direction_reg);
	wire [7:0] p5_rd = (port5_data_reg & port5_direction_reg) | (p5_level & ~port5_direction_reg);
	wire [7:0] p6_rd = (port6_data_reg & port6_direction_reg) | (p6_level & ~port6_direction_reg);
	wire [7:0] p7_rd = (port7_data_reg & port7_direction_reg) | (p7_level & ~port7_direction_reg);
	// Direction, pull-up, open-drain and alt select are absent here: read zero
	wire [7:0] rd_byte =
		!aligned ? 8'h00 :
		hit_p1_data ? p1_rd :
		hit_p2_data ? p2_rd :
		hit_p4_data ? p4_rd :
		hit_p5_data ? p5_rd :
		hit_p6_data ? p6_rd :
		hit_p7_data ? p7_rd :
		hit_p5_seg ? port5_segment_select_reg :
		hit_p6_seg ? port6_segment_select_reg :
		hit_p7_seg ? port7_segment_select_reg :
		hit_lcd ? lcd_control_register_reg :
		8'h00;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_start) begin
			readdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign readdata = readdata_reg;
endmodule

// File: rtl/gpio_cfg.svh
// Register indices, field positions and reset values of the GPIO block.
// Assumes a byte address on the bus equal to four times the index.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// --------
// Register indices
// --------
`define IDX_PORT1_OPEN_DRAIN_SELECT 8'hA1
`define IDX_PORT2_OPEN_DRAIN_SELECT 8'hA2
`define IDX_PORT4_OPEN_DRAIN_SELECT 8'hA4
`define IDX_PORT1_PULLUP_SELECT 8'hA6
`define IDX_PORT2_PULLUP_SELECT 8'hA7
`define IDX_PORT4_PULLUP_SELECT 8'hA8
`define IDX_ALT_FUNCTION_SELECT_B 8'hAB
`define IDX_PORT5_SEGMENT_SELECT 8'hAC
`define IDX_PORT6_SEGMENT_SELECT 8'hAD
`define IDX_PORT7_SEGMENT_SELECT 8'hAE
`define IDX_PORT7_DATA 8'hB0
`define IDX_PORT7_DIRECTION 8'hB4
`define IDX_LCD_CONTROL_REGISTER 8'hB8
`define IDX_PORT1_DATA 8'hC2
`define IDX_PORT1_DIRECTION 8'hC3
`define IDX_PORT2_DATA 8'hC4
`define IDX_PORT2_DIRECTION 8'hC5
`define IDX_PORT4_DATA 8'hC8
`define IDX_PORT4_DIRECTION 8'hC9
`define IDX_PORT5_DATA 8'hCA
`define IDX_PORT5_DIRECTION 8'hCB
`define IDX_PORT6_DATA 8'hCC
`define IDX_PORT6_DIRECTION 8'hCD

// --------
// Fields and reset values
// --------
`define ALT_PWM_ONE_BIT 0
`define ALT_INT_TWO_BIT 1
`define ALT_INT_THREE_BIT 2
`define LCD_SUB_CLOCK_DISABLE_BIT 0
`define GPIO_RESET_BYTE 8'h00
`define PORT2_SMALL_PACKAGE_MASK 8'hA0
`define PORT4_INT_THREE_PIN 1
`define PORT4_RESET_PIN 7

`endif

// File: rtl/gpio_pkg.sv
// Types shared by the GPIO block files.
// Assumes nothing beyond a SystemVerilog compiler.
package gpio_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [9:0] bus_addr_t;
endpackage

// File: rtl/gpio_pin_cell.sv
// One GPIO port's pad control: output mux, open drain and pin synchroniser.
// Assumes pad signals from outside the clock domain and registers on clk_sys.
`timescale 1ns/1ps
module gpio_pin_cell
	import gpio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] open_drain,
	input wire logic [WIDTH-1:0] pull_sel,
	input wire logic [WIDTH-1:0] alt_sel,
	input wire logic [WIDTH-1:0] alt_out,
	input wire logic [WIDTH-1:0] alt_drive,
	input wire logic [WIDTH-1:0] in_only,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pin_pullup,
	output logic [WIDTH-1:0] level
);
	// --------
	// Output path
	// --------
	logic [WIDTH-1:0] sync_a_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] oe_reg;
	logic [WIDTH-1:0] pu_reg;
	wire [WIDTH-1:0] drive_val = (alt_sel & alt_out) | (~alt_sel & latch);
	wire [WIDTH-1:0] eff_dir = ((alt_sel & alt_drive) | (~alt_sel & dir)) & ~in_only;
	// Open drain only sinks: the enable drops while the value is high
	wire [WIDTH-1:0] oe_next = eff_dir & (~open_drain | ~drive_val);
	wire [WIDTH-1:0] out_next = drive_val & ~open_drain;
	wire [WIDTH-1:0] pu_next = pull_sel & ~in_only;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_reg <= '0;
			oe_reg <= '0;
			pu_reg <= '0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			pu_reg <= pu_next;
		end
	end

	// --------
	// Input synchroniser
	// --------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync_a_reg <= '0;
			level <= '0;
		end else begin
			sync_a_reg <= pin_in;
			level <= sync_a_reg;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign pin_pullup = pu_reg;
endmodule

// File: tb/gpio_ports_props.sv
// Concurrent checks on the GPIO block's bus and pin ports.
// Assumes binding into gpio_ports; sees only that module's ports.
`timescale 1ns/1ps
`include "gpio_cfg.svh"
module gpio_ports_props
	import gpio_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [7:0] port1_pin_oe,
	input wire logic [7:0] port1_pin_pullup,
	input wire logic [7:0] port4_pin_in,
	input wire logic [7:0] port4_pin_oe,
	input wire logic [7:0] port4_pin_pullup,
	input wire logic option_main_osc_as_io,
	input wire logic external_interrupt_three,
	input wire logic external_interrupt_two_select,
	input wire logic main_osc_pins_dedicated
);
	// --------
	// Bus and pin properties
	// --------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_one_wait_state: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait state");
	a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	a_port1_wo_zero: assert property (read && !waitrequest && address[9:2] inside {`IDX_PORT1_DIRECTION,
		`IDX_PORT1_PULLUP_SELECT, `IDX_PORT1_OPEN_DRAIN_SELECT, `IDX_ALT_FUNCTION_SELECT_B} |-> readdata == 32'h0000_0000)
		else $error("port 1 control register readable");
	a_port2_wo_zero: assert property (read && !waitrequest && address[9:2] inside {`IDX_PORT2_DIRECTION,
		`IDX_PORT2_PULLUP_SELECT, `IDX_PORT2_OPEN_DRAIN_SELECT} |-> readdata == 32'h0000_0000)
		else $error("port 2 control register readable");
	a_port4_wo_zero: assert property (read && !waitrequest && address[9:2] inside {`IDX_PORT4_DIRECTION,
		`IDX_PORT4_PULLUP_SELECT, `IDX_PORT4_OPEN_DRAIN_SELECT} |-> readdata == 32'h0000_0000)
		else $error("port 4 control register readable");
	a_seg_dir_wo: assert property (read && !waitrequest && address[9:2] inside {`IDX_PORT5_DIRECTION,
		`IDX_PORT6_DIRECTION, `IDX_PORT7_DIRECTION} |-> readdata == 32'h0000_0000)
		else $error("port 5 to 7 direction readable");
	a_reset_clear: assert property ($rose(rst_n) |-> port1_pin_oe == 8'h00 && port1_pin_pullup == 8'h00 &&
		port4_pin_oe == 8'h00 && !external_interrupt_two_select)
		else $error("pins not idle after reset");
	a_int_three_pin: assert property (external_interrupt_three |-> $past(port4_pin_in[1], 2))
		else $error("interrupt request without pin level");
	a_osc_option: assert property ($past(rst_n, 2) && $past(rst_n) |->
		main_osc_pins_dedicated == !$past(option_main_osc_as_io, 2))
		else $error("oscillator option not followed");
	a_osc_pins_in: assert property (main_osc_pins_dedicated && $past(main_osc_pins_dedicated) |->
		port4_pin_oe[6:5] == 2'b00 && port4_pin_pullup[6:5] == 2'b00)
		else $error("oscillator pins driven while dedicated");
	a_reset_pin_in: assert property (port4_pin_oe[7] == 1'b0 && port4_pin_pullup[7] == 1'b0)
		else $error("reset pin driven");
endmodule

bind gpio_ports gpio_ports_props gpio_ports_props_i (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .port1_pin_oe(port1_pin_oe),
	.port1_pin_pullup(port1_pin_pullup), .port4_pin_in(port4_pin_in), .port4_pin_oe(port4_pin_oe),
	.port4_pin_pullup(port4_pin_pullup), .option_main_osc_as_io(option_main_osc_as_io),
	.external_interrupt_three(external_interrupt_three),
	.external_interrupt_two_select(external_interrupt_two_select),
	.main_osc_pins_dedicated(main_osc_pins_dedicated));

// File: tb/gpio_pad_model.sv
// Pad model of one eight-pin port: design drive, pull-up and the outside world.
// Assumes the bench sets what the outside drives; other pins float.
`timescale 1ns/1ps
module gpio_pad_model
	import gpio_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic [7:0] ext_level,
	input wire logic [7:0] ext_drive,
	output logic [7:0] pin_in
);
	byte_t last_reg = 8'h00;
	// Floating pins flip, so a stale level can never pass
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) | (~pin_oe & ~ext_drive & pin_pullup) |
		(~pin_oe & ~ext_drive & ~pin_pullup & ~last_reg);
	always_ff @(posedge clk_sys) begin
		last_reg <= pin_in;
	end
endmodule

// File: tb/gpio_ports_test.sv
// Self-checking bench: random byte traffic on all ports against a register model.
// Assumes one pad model per port and the one-wait-state bus answer.
`timescale 1ns/1ps
`include "gpio_cfg.svh"
module gpio_ports_test
	import gpio_pkg::*;
;
	// --------
	// Tables and signals
	// --------
	localparam byte_t DAT [6] = '{`IDX_PORT1_DATA, `IDX_PORT2_DATA, `IDX_PORT4_DATA, `IDX_PORT5_DATA,
		`IDX_PORT6_DATA, `IDX_PORT7_DATA};
	localparam byte_t DIR [6] = '{`IDX_PORT1_DIRECTION, `IDX_PORT2_DIRECTION, `IDX_PORT4_DIRECTION,
		`IDX_PORT5_DIRECTION, `IDX_PORT6_DIRECTION, `IDX_PORT7_DIRECTION};
	localparam byte_t ODS [6] = '{`IDX_PORT1_OPEN_DRAIN_SELECT, `IDX_PORT2_OPEN_DRAIN_SELECT,
		`IDX_PORT4_OPEN_DRAIN_SELECT, 8'h00, 8'h00, 8'h00};
	localparam byte_t PUS [6] = '{`IDX_PORT1_PULLUP_SELECT, `IDX_PORT2_PULLUP_SELECT, `IDX_PORT4_PULLUP_SELECT,
		8'h00, 8'h00, 8'h00};
	localparam byte_t SGS [6] = '{8'h00, 8'h00, 8'h00, `IDX_PORT5_SEGMENT_SELECT, `IDX_PORT6_SEGMENT_SELECT,
		`IDX_PORT7_SEGMENT_SELECT};
	localparam byte_t CTRL [17] = '{DIR[0], ODS[0], PUS[0], `IDX_ALT_FUNCTION_SELECT_B, DIR[1], ODS[1], PUS[1],
		DIR[2], ODS[2], PUS[2], DIR[3], DIR[4], DIR[5], SGS[3], SGS[4], SGS[5], `IDX_LCD_CONTROL_REGISTER};
	localparam bit [16:0] RDBL = 17'h1_E000;
	localparam byte_t UNMAPPED = 8'h10;
	localparam byte_t ALT = `IDX_ALT_FUNCTION_SELECT_B;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] address = 10'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'h0;
	logic pwm_level = 1'b0;
	logic [23:0] lcd_level = 24'h00_0000;
	logic opt_main = 1'b0;
	logic opt_rst = 1'b0;
	wire [31:0] readdata;
	wire waitrequest, ext_int_three, int_two_sel, sub_clk_off, osc_dedicated, reset_pin_n;
	wire [7:0] p_in [6];
	wire [7:0] p_out [6];
	wire [7:0] p_oe [6];
	wire [7:0] p_pu [6];
	byte_t ext [6] = '{default: 8'h00};
	byte_t ext_en [6] = '{default: 8'hFF};
	byte_t rm [256] = '{default: 8'h00};
	int n_errors = 0;
	int n_tests = 0;
	int pick;
	assign p_pu[3] = 8'h00;
	assign p_pu[4] = 8'h00;
	assign p_pu[5] = 8'h00;
	always #2 clk_sys = ~clk_sys;

	gpio_ports #(.SMALL_PACKAGE(1'b0)) gpio_ports_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.port1_pin_in(p_in[0]), .port1_pin_out(p_out[0]), .port1_pin_oe(p_oe[0]), .port1_pin_pullup(p_pu[0]),
		.port2_pin_in(p_in[1]), .port2_pin_out(p_out[1]), .port2_pin_oe(p_oe[1]), .port2_pin_pullup(p_pu[1]),
		.port4_pin_in(p_in[2]), .port4_pin_out(p_out[2]), .port4_pin_oe(p_oe[2]), .port4_pin_pullup(p_pu[2]),
		.port5_pin_in(p_in[3]), .port5_pin_out(p_out[3]), .port5_pin_oe(p_oe[3]),
		.port6_pin_in(p_in[4]), .port6_pin_out(p_out[4]), .port6_pin_oe(p_oe[4]),
		.port7_pin_in(p_in[5]), .port7_pin_out(p_out[5]), .port7_pin_oe(p_oe[5]),
		.pwm_one_output(pwm_level), .lcd_segment(lcd_level), .option_main_osc_as_io(opt_main),
		.option_reset_as_io(opt_rst), .external_interrupt_three(ext_int_three),
		.external_interrupt_two_select(int_two_sel), .sub_clock_disable(sub_clk_off),
		.main_osc_pins_dedicated(osc_dedicated), .reset_pin_n(reset_pin_n));
	for (genvar k = 0; k < 6; k++) begin : g_pad
		gpio_pad_model gpio_pad_model_i (.clk_sys(clk_sys), .pin_out(p_out[k]), .pin_oe(p_oe[k]),
			.pin_pullup(p_pu[k]), .ext_level(ext[k]), .ext_drive(ext_en[k]), .pin_in(p_in[k]));
	end

	// --------
	// Bus tasks and comparisons
	// --------
	task automatic bus_write(input byte_t idx, input byte_t d, input logic [3:0] be);
		@(posedge clk_sys);
		address <= {idx, 2'b00};
		writedata <= {24'h00_0000, d};
		byteenable <= be;
		write <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		write <= 1'b0;
		if (be[0] && idx != UNMAPPED) rm[idx] = d;
	endtask

	task automatic bus_read(input byte_t idx, output logic [31:0] rd);
		@(posedge clk_sys);
		address <= {idx, 2'b00};
		read <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
	endtask

	task automatic check_read(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m, input string what);
		n_tests++;
		if ((got & m) !== (exp & m)) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s read %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_pin(input byte_t got, input byte_t exp, input byte_t m, input string what);
		n_tests++;
		if ((got & m) !== (exp & m)) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_all();
		byte_t oe, po, pu, io, lv, d, l;
		logic [31:0] rd;
		for (int k = 0; k < 6; k++) begin
			d = rm[DIR[k]];
			l = rm[DAT[k]];
			pu = rm[PUS[k]];
			oe = (d & ~(rm[ODS[k]] & l)) | rm[SGS[k]];
			po = (l & ~rm[ODS[k]] & ~rm[SGS[k]]) | (rm[SGS[k]] & ((k > 2) ? byte_t'(lcd_level >> (8 * (k - 3))) : 8'h00));
			io = 8'h00;
			if (k == 0 && rm[ALT][0]) begin
				oe[0] = ~(rm[ODS[0]][0] & pwm_level);
				po[0] = pwm_level;
			end
			if (k == 2) begin
				io = 8'h80 | (opt_main ? 8'h00 : 8'h60) | (rm[`IDX_LCD_CONTROL_REGISTER][0] ? 8'h00 : 8'h18);
				oe = oe & ~io;
				oe[1] = oe[1] & ~rm[ALT][2];
				pu = pu & ~io;
			end
			lv = (oe & po) | (~oe & ext_en[k] & ext[k]) | (~oe & ~ext_en[k] & pu);
			check_pin(p_oe[k], oe, 8'hFF, "oe");
			check_pin(p_out[k], po, oe, "out");
			check_pin(p_pu[k], pu, 8'hFF, "pull-up");
			bus_read(DAT[k], rd);
			check_read(rd, {24'h00_0000, (d & l) | (~d & lv)}, {24'hFF_FFFF, d | oe | ext_en[k] | pu}, "data");
		end
		for (int j = 0; j < 18; j++) begin
			bus_read((j < 17) ? CTRL[j] : UNMAPPED, rd);
			check_read(rd, (j < 17 && RDBL[j]) ? {24'h00_0000, rm[CTRL[j]]} : 32'h0000_0000, 32'hFFFF_FFFF, "reg");
		end
		check_pin({7'h00, ext_int_three}, {7'h00, rm[ALT][2] & ext[2][1]}, 8'hFF, "int");
		check_pin({4'h0, int_two_sel, sub_clk_off, osc_dedicated, reset_pin_n}, {4'h0, rm[ALT][1],
			rm[`IDX_LCD_CONTROL_REGISTER][0], ~opt_main, opt_rst | ext[2][7]}, 8'hFF, "side");
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// --------
	// Main sequence and watchdog
	// --------
	initial begin
		void'($urandom(2));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int it = 0; it < 60; it++) begin
			// First pass checks reset state; later passes make three writes, one idle cycle apart
			if (it > 0) begin
				repeat (3) begin
					pick = $urandom_range(0, 23);
					bus_write((pick < 17) ? CTRL[pick] : (pick < 23) ? DAT[pick - 17] : UNMAPPED,
						byte_t'($urandom), ($urandom_range(0, 7) == 0) ? 4'h0 : 4'hF);
				end
				for (int k = 0; k < 6; k++) begin
					ext[k] <= byte_t'($urandom);
					ext_en[k] <= (k == 2) ? 8'hFF : byte_t'($urandom);
				end
				pwm_level <= 1'($urandom);
				lcd_level <= 24'($urandom);
				opt_main <= ($urandom_range(0, 3) == 0);
				opt_rst <= 1'($urandom);
			end
			repeat (6) @(posedge clk_sys);
			check_all();
		end
		results();
	end

	initial begin
		#100000;
		n_errors++;
		results();
	end
endmodule
